// ### spos_pin_watch.sv
// Far-end observer sampling the multifunction pin
`timescale 1ns/1ps
`default_nettype none
module spos_pin_watch (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pin under watch and its sampled level
    input wire logic multifunction_pin,
    output var logic seen_level
);
    // Registers the pin once per clock, as external logic would
    always_ff @(posedge aclk) begin
        if (!aresetn) seen_level <= 1'b0;
        else seen_level <= multifunction_pin;
    end
endmodule
`default_nettype wire

// ### spos_pkg.sv
// Package for the status pin output selector: register map, function codes, input bundles
package spos_pkg;

    // Register byte offsets on the AXI4-Lite bus
    localparam logic [11:0] SPOS_FUNC_SEL_OFFSET = 12'h000;
    localparam logic [11:0] SPOS_PIN_STATE_OFFSET = 12'h004;
    localparam int SPOS_ADDR_WIDTH = 12;

    // Field layout and reset values
    localparam int SPOS_FUNC_CODE_LSB = 0;
    localparam int SPOS_FUNC_CODE_MSB = 7;
    localparam int SPOS_PIN_LEVEL_BIT = 0;
    localparam int SPOS_RESERVED_BIT = 1;
    localparam logic [7:0] SPOS_FUNC_CODE_RESET = 8'h00;
    localparam logic SPOS_PIN_INACTIVE = 1'b0;

    // AXI responses
    localparam logic [1:0] SPOS_RESP_OKAY = 2'h0;
    localparam logic [1:0] SPOS_RESP_DECERR = 2'h3;

    // Function codes steering the multifunction pin
    localparam logic [7:0] SPOS_CODE_CONV1_ACTIVE = 8'h2F;
    localparam logic [7:0] SPOS_CODE_CH0_PHASE_LOCK = 8'h30;
    localparam logic [7:0] SPOS_CODE_CH0_FREQ_LOCK = 8'h31;
    localparam logic [7:0] SPOS_CODE_CH0_ALOOP_LOCK = 8'h32;
    localparam logic [7:0] SPOS_CODE_CH0_ALOOP_CAL = 8'h33;
    localparam logic [7:0] SPOS_CODE_CH0_HOLDOVER = 8'h36;
    localparam logic [7:0] SPOS_CODE_CH0_SWITCHING = 8'h37;
    localparam logic [7:0] SPOS_CODE_CH0_HIST_AVAIL = 8'h38;
    localparam logic [7:0] SPOS_CODE_CH0_HIST_UPD = 8'h39;
    localparam logic [7:0] SPOS_CODE_CH0_CLAMP = 8'h3A;
    localparam logic [7:0] SPOS_CODE_CH0_SLEW = 8'h3B;
    localparam logic [7:0] SPOS_CODE_CH0_DIST_SYNC = 8'h3C;
    localparam logic [7:0] SPOS_CODE_CH0_PHASE_STEP = 8'h3E;
    localparam logic [7:0] SPOS_CODE_CH0_FACQ_ACTIVE = 8'h3F;
    localparam logic [7:0] SPOS_CODE_CH0_FACQ_DONE = 8'h40;
    localparam logic [7:0] SPOS_CODE_CH0_DIV_RESYNC = 8'h41;
    localparam logic [7:0] SPOS_CODE_CH0_DIST_SLEW = 8'h42;
    localparam logic [7:0] SPOS_CODE_CH0_DIST_CFG_ERR = 8'h43;
    localparam logic [7:0] SPOS_CODE_CH1_PHASE_LOCK = 8'h50;
    localparam logic [7:0] SPOS_CODE_CH1_FREQ_LOCK = 8'h51;
    localparam logic [7:0] SPOS_CODE_CH1_ALOOP_LOCK = 8'h52;
    localparam logic [7:0] SPOS_CODE_CH1_ALOOP_CAL = 8'h53;
    localparam logic [7:0] SPOS_CODE_CH1_TRACKING = 8'h54;
    localparam logic [7:0] SPOS_CODE_CH1_FREERUN = 8'h55;
    localparam logic [7:0] SPOS_CODE_CH1_HOLDOVER = 8'h56;
    localparam logic [7:0] SPOS_CODE_CH1_SWITCHING = 8'h57;
    localparam logic [7:0] SPOS_CODE_CH1_HIST_AVAIL = 8'h58;
    localparam logic [7:0] SPOS_CODE_CH1_HIST_UPD = 8'h59;
    localparam logic [7:0] SPOS_CODE_CH1_CLAMP = 8'h5A;
    localparam logic [7:0] SPOS_CODE_CH1_SLEW = 8'h5B;
    localparam logic [7:0] SPOS_CODE_CH1_DIST_SYNC = 8'h5C;
    localparam logic [7:0] SPOS_CODE_CH1_PHASE_STEP = 8'h5E;
    localparam logic [7:0] SPOS_CODE_CH1_FACQ_ACTIVE = 8'h5F;
    localparam logic [7:0] SPOS_CODE_CH1_FACQ_DONE = 8'h60;
    localparam logic [7:0] SPOS_CODE_CH1_DIV_RESYNC = 8'h61;
    localparam logic [7:0] SPOS_CODE_CH1_DIST_SLEW = 8'h62;
    localparam logic [7:0] SPOS_CODE_CH1_DIST_CFG_ERR = 8'h63;
    localparam logic [7:0] SPOS_CODE_OSC0_FUND = 8'h70;
    localparam logic [7:0] SPOS_CODE_OSC0_TAGGED = 8'h71;
    localparam logic [7:0] SPOS_CODE_OSC1_FUND = 8'h72;
    localparam logic [7:0] SPOS_CODE_OSC1_TAGGED = 8'h73;
    localparam logic [7:0] SPOS_CODE_AUX_REF_FAULT = 8'h75;
    localparam logic [7:0] SPOS_CODE_STAMP0_READY = 8'h78;
    localparam logic [7:0] SPOS_CODE_STAMP1_READY = 8'h79;

    // Status and event bundle of one digital loop channel
    typedef struct packed {
        logic phase_lock;
        logic freq_lock;
        logic analog_loop_lock;
        logic analog_loop_cal;
        logic tracking;
        logic freerun;
        logic holdover;
        logic switching;
        logic hist_avail;
        logic hist_updated;
        logic freq_clamp;
        logic slew_limit;
        logic dist_sync;
        logic phase_step;
        logic facq_active;
        logic facq_done;
        logic div_resync;
        logic dist_slew;
        logic dist_cfg_err;
    } spos_channel_type;

    // Auxiliary sources: converter, oscillators, aux loop, timestamps
    typedef struct packed {
        logic conv1_active;
        logic osc0_fund;
        logic osc0_tagged;
        logic osc1_fund;
        logic osc1_tagged;
        logic aux_ref_fault;
        logic stamp0_ready;
        logic stamp1_ready;
    } spos_aux_type;

endpackage

// ### spos_props.sv
// Checker for the status pin selector: bus handshakes and pin routing
`timescale 1ns/1ps
`default_nettype none
module spos_props
    import spos_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [SPOS_ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [SPOS_ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Sources and pin
    input wire spos_channel_type channel_0,
    input wire spos_channel_type channel_1,
    input wire spos_aux_type aux_status,
    input wire logic multifunction_pin
);
    logic aw_sel;
    logic w_en;
    logic [7:0] w_byte;
    logic [7:0] code_q;
    logic [7:0] prev_code;
    logic steady;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Captures the write in flight
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) aw_sel <= (s_axi_awaddr == SPOS_FUNC_SEL_OFFSET);
        if (s_axi_wvalid && s_axi_wready) begin
            w_en <= s_axi_wstrb[0];
            w_byte <= s_axi_wdata[7:0];
        end
    end
    // Shadow code, taken over once the write response is accepted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            code_q <= SPOS_FUNC_CODE_RESET;
            prev_code <= SPOS_FUNC_CODE_RESET;
        end else begin
            prev_code <= code_q;
            if (s_axi_bvalid && s_axi_bready && aw_sel && w_en) code_q <= w_byte;
        end
    end
    // Pin is judged only once the code has settled for a cycle
    assign steady = (code_q == prev_code) && !s_axi_bvalid;
    conv_route_a: assert property (steady && code_q == 8'h2F
        |-> multifunction_pin == $past(aux_status.conv1_active)) else $error("Pin lost converter");
    lock_route_a: assert property (steady && code_q == 8'h30
        |-> multifunction_pin == $past(channel_0.phase_lock)) else $error("Pin lost lock");
    step_route_a: assert property (steady && code_q == 8'h5E
        |-> multifunction_pin == $past(channel_1.phase_step)) else $error("Pin lost step");
    stamp_route_a: assert property (steady && code_q == 8'h79
        |-> multifunction_pin == $past(aux_status.stamp1_ready)) else $error("Pin lost stamp");
    reserved_low_a: assert property (steady && code_q inside {8'h34, 8'h35, 8'h74, 8'h7A}
        |-> !multifunction_pin) else $error("Pin active on reserved code");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("Write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("Read data dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready) else $error("Read not answered");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("Write not answered");
    decode_err_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[11:3] != 0
        |=> s_axi_rresp == SPOS_RESP_DECERR && s_axi_rdata == 0) else $error("No decode error");
endmodule
`default_nettype wire

// ### spos_selector.sv
// Multifunction status pin selector with AXI4-Lite register slave
// Function
// - 0x2F drives time_converter 1 activity
// - 0x30-0x33 channel 0 lock and calibration
// - 0x36/0x37 channel 0 holdover and switching
// - 0x38/0x3A/0x3B history, clamp, slew channel 0
// - 0x39 channel 0 history updated event
// - 0x3E phase step, 0x3F fast acquisition
// - Channel 0 fast acquisition complete selectable
// - 0x41 channel 0 divider resync event
// - 0x42/0x43 channel 0 distribution events
// - Channel 0 distribution sync event selectable
// - 0x50-0x53 channel 1 lock and calibration
// - 0x54 tracking, 0x55 freerun channel 1
// - 0x56/0x57 channel 1 holdover and switching
// - 0x58-0x5B channel 1 history, clamp, slew
// - 0x5C distribution sync, 0x5E phase step
// - 0x5F/0x60 fast acquisition, 0x61 resync
// - 0x62/0x63 channel 1 distribution events
// - 0x70-0x73 auxiliary oscillator outputs
// - 0x75 auxiliary loop reference fault
// - 0x78/0x79 timestamp code available
`timescale 1ns/1ps
`default_nettype none

module spos_selector
    import spos_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address channel
    input wire logic [SPOS_ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address channel
    input wire logic [SPOS_ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Internal status sources, same clock domain
    input wire spos_channel_type channel_0,
    input wire spos_channel_type channel_1,
    input wire spos_aux_type aux_status,
    // Pin
    output logic multifunction_pin
);

    logic [7:0] func_code;
    logic aw_got;
    logic w_got;
    logic [SPOS_ADDR_WIDTH-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_fire;
    logic code_reserved;
    logic next_pin;
    logic next_reserved;

    // Word-aligned decode shared by both paths
    function automatic logic is_reg(input logic [SPOS_ADDR_WIDTH-1:0] addr,
                                    input logic [SPOS_ADDR_WIDTH-1:0] offs);
        is_reg = (addr[SPOS_ADDR_WIDTH-1:2] == offs[SPOS_ADDR_WIDTH-1:2]);
    endfunction

    assign wr_fire = aw_got && w_got && !s_axi_bvalid;

    // Write address and data capture, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                wr_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!aw_got && !s_axi_bvalid && !wr_fire) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (!w_got && !s_axi_bvalid && !wr_fire) begin
                s_axi_wready <= 1'b1;
            end
            if (wr_fire) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
            end
        end
    end

    // Write response once both halves are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SPOS_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_reg(wr_addr, SPOS_FUNC_SEL_OFFSET) ||
                           is_reg(wr_addr, SPOS_PIN_STATE_OFFSET) ?
                           SPOS_RESP_OKAY : SPOS_RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Function code register, byte lane 0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            func_code <= SPOS_FUNC_CODE_RESET;
        end else if (wr_fire && wr_strb[0] && is_reg(wr_addr, SPOS_FUNC_SEL_OFFSET)) begin
            func_code <= wr_data[SPOS_FUNC_CODE_MSB:SPOS_FUNC_CODE_LSB];
        end
    end

    // Read channel: one cycle from address to data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= SPOS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= '0;
            s_axi_rresp <= SPOS_RESP_OKAY;
            if (is_reg(s_axi_araddr, SPOS_FUNC_SEL_OFFSET)) begin
                s_axi_rdata[SPOS_FUNC_CODE_MSB:SPOS_FUNC_CODE_LSB] <= func_code;
            end else if (is_reg(s_axi_araddr, SPOS_PIN_STATE_OFFSET)) begin
                s_axi_rdata[SPOS_PIN_LEVEL_BIT] <= multifunction_pin;
                s_axi_rdata[SPOS_RESERVED_BIT] <= code_reserved;
            end else begin
                s_axi_rresp <= SPOS_RESP_DECERR;
            end
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // Source selection from the function code
    always_comb begin
        next_pin = SPOS_PIN_INACTIVE;
        next_reserved = 1'b0;
        case (func_code)
            SPOS_CODE_CONV1_ACTIVE: next_pin = aux_status.conv1_active;
            SPOS_CODE_CH0_PHASE_LOCK: next_pin = channel_0.phase_lock;
            SPOS_CODE_CH0_FREQ_LOCK: next_pin = channel_0.freq_lock;
            SPOS_CODE_CH0_ALOOP_LOCK: next_pin = channel_0.analog_loop_lock;
            SPOS_CODE_CH0_ALOOP_CAL: next_pin = channel_0.analog_loop_cal;
            SPOS_CODE_CH0_HOLDOVER: next_pin = channel_0.holdover;
            SPOS_CODE_CH0_SWITCHING: next_pin = channel_0.switching;
            SPOS_CODE_CH0_HIST_AVAIL: next_pin = channel_0.hist_avail;
            SPOS_CODE_CH0_HIST_UPD: next_pin = channel_0.hist_updated;
            SPOS_CODE_CH0_CLAMP: next_pin = channel_0.freq_clamp;
            SPOS_CODE_CH0_SLEW: next_pin = channel_0.slew_limit;
            SPOS_CODE_CH0_DIST_SYNC: next_pin = channel_0.dist_sync;
            SPOS_CODE_CH0_PHASE_STEP: next_pin = channel_0.phase_step;
            SPOS_CODE_CH0_FACQ_ACTIVE: next_pin = channel_0.facq_active;
            SPOS_CODE_CH0_FACQ_DONE: next_pin = channel_0.facq_done;
            SPOS_CODE_CH0_DIV_RESYNC: next_pin = channel_0.div_resync;
            SPOS_CODE_CH0_DIST_SLEW: next_pin = channel_0.dist_slew;
            SPOS_CODE_CH0_DIST_CFG_ERR: next_pin = channel_0.dist_cfg_err;
            SPOS_CODE_CH1_PHASE_LOCK: next_pin = channel_1.phase_lock;
            SPOS_CODE_CH1_FREQ_LOCK: next_pin = channel_1.freq_lock;
            SPOS_CODE_CH1_ALOOP_LOCK: next_pin = channel_1.analog_loop_lock;
            SPOS_CODE_CH1_ALOOP_CAL: next_pin = channel_1.analog_loop_cal;
            SPOS_CODE_CH1_TRACKING: next_pin = channel_1.tracking;
            SPOS_CODE_CH1_FREERUN: next_pin = channel_1.freerun;
            SPOS_CODE_CH1_HOLDOVER: next_pin = channel_1.holdover;
            SPOS_CODE_CH1_SWITCHING: next_pin = channel_1.switching;
            SPOS_CODE_CH1_HIST_AVAIL: next_pin = channel_1.hist_avail;
            SPOS_CODE_CH1_HIST_UPD: next_pin = channel_1.hist_updated;
            SPOS_CODE_CH1_CLAMP: next_pin = channel_1.freq_clamp;
            SPOS_CODE_CH1_SLEW: next_pin = channel_1.slew_limit;
            SPOS_CODE_CH1_DIST_SYNC: next_pin = channel_1.dist_sync;
            SPOS_CODE_CH1_PHASE_STEP: next_pin = channel_1.phase_step;
            SPOS_CODE_CH1_FACQ_ACTIVE: next_pin = channel_1.facq_active;
            SPOS_CODE_CH1_FACQ_DONE: next_pin = channel_1.facq_done;
            SPOS_CODE_CH1_DIV_RESYNC: next_pin = channel_1.div_resync;
            SPOS_CODE_CH1_DIST_SLEW: next_pin = channel_1.dist_slew;
            SPOS_CODE_CH1_DIST_CFG_ERR: next_pin = channel_1.dist_cfg_err;
            SPOS_CODE_OSC0_FUND: next_pin = aux_status.osc0_fund;
            SPOS_CODE_OSC0_TAGGED: next_pin = aux_status.osc0_tagged;
            SPOS_CODE_OSC1_FUND: next_pin = aux_status.osc1_fund;
            SPOS_CODE_OSC1_TAGGED: next_pin = aux_status.osc1_tagged;
            SPOS_CODE_AUX_REF_FAULT: next_pin = aux_status.aux_ref_fault;
            SPOS_CODE_STAMP0_READY: next_pin = aux_status.stamp0_ready;
            SPOS_CODE_STAMP1_READY: next_pin = aux_status.stamp1_ready;
            default: begin
                next_pin = SPOS_PIN_INACTIVE;
                next_reserved = 1'b1;
            end
        endcase
    end

    // Registered pin driver; an event pulse appears one cycle late
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            multifunction_pin <= SPOS_PIN_INACTIVE;
            code_reserved <= 1'b1;
        end else begin
            multifunction_pin <= next_pin;
            code_reserved <= next_reserved;
        end
    end

endmodule

`default_nettype wire

// ### spos_selector_bench.sv
// Self-checking bench for the status pin selector
`timescale 1ns/1ps
`default_nettype none
module spos_selector_bench
    import spos_pkg::*;
();
    logic aclk = 0, aresetn = 0, wr_on = 0, seen_level, multifunction_pin, lvl = 0;
    logic [SPOS_ADDR_WIDTH-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, sel_q = '0, sel_d = '0;
    spos_channel_type channel_0 = '0, channel_1 = '0;
    spos_aux_type aux_status = '0;
    int n_fail = 0, num_checks = 0, model_code = 0, hold = 8;
    spos_selector uut (.*);
    spos_pin_watch far_end (.aclk, .aresetn, .multifunction_pin, .seen_level);
    initial forever #12.5 aclk = ~aclk;
    // Reference selection, returns {reserved, level}
    function automatic logic [1:0] ref_sel(input int c, input spos_channel_type a,
        input spos_channel_type b, input spos_aux_type x);
        int o;
        logic [18:0] ch;
        o = c - (c < 8'h50 ? 8'h30 : 8'h50);
        ch = (c < 8'h50) ? a : b;
        if (((c >= 8'h30 && c <= 8'h43 && o != 4 && o != 5) || (c >= 8'h50 && c <= 8'h63))
            && o != 13) return {1'b0, ch[o <= 12 ? 18 - o : 19 - o]};
        case (c)
            8'h2F: o = 7;
            8'h70, 8'h71, 8'h72, 8'h73: o = 8'h76 - c;
            8'h75: o = 2;
            8'h78, 8'h79: o = 8'h79 - c;
            default: return 2'h2;
        endcase
        return {1'b0, x[o]};
    endfunction
    // Compare and count
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One AXI4-Lite write or read, waiting for the response
    task automatic axi(input logic w, input logic [11:0] a, input logic [31:0] wd,
        input logic [3:0] s, output logic [31:0] d, output logic [1:0] r);
        logic lag;
        lag = 1'($urandom);
        wr_on = w;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {a, a, wd, s};
        // Ready rises with the request, or only once the answer shows, so holds are exercised
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <=
            {w, w, w && !lag, !w, !w && !lag};
        // No cycle count assumed here: only the watchdog ends a hung wait
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                lvl = sel_q[0];
            end
            if ((s_axi_bvalid || s_axi_rvalid) && !s_axi_bready && !s_axi_rready) begin
                {s_axi_bready, s_axi_rready} <= {w, !w};
            end
        end while (!((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)));
        {d, r} = w ? {32'h0, s_axi_bresp} : {s_axi_rdata, s_axi_rresp};
        {s_axi_bready, s_axi_rready} <= 2'h0;
        if (w && a == SPOS_FUNC_SEL_OFFSET && s[0]) model_code = int'(wd[7:0]);
        hold = 4;
        wr_on = 0;
    endtask
    // Random sources and the reference pin pipeline
    always @(posedge aclk) begin
        sel_q <= aresetn ? ref_sel(model_code, channel_0, channel_1, aux_status) : 2'h2;
        sel_d <= sel_q;
        {channel_0, channel_1, aux_status} <= 46'({$urandom, $urandom});
        if (hold > 0) hold--;
    end
    // Pin and far-end samples against the reference
    always @(negedge aclk) if (aresetn && !wr_on && hold == 0) begin
        check("pin", sel_q[0], multifunction_pin);
        check("far", sel_d[0], seen_level);
    end
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #1000000;
        n_fail++;
        print_verdict();
    end
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [1:0] v;
        void'($urandom(92107));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        // Codes 0x00-0x7F back to back: write, let sources run, read code and reserved flag
        for (int c = 0; c < 128; c++) begin
            axi(1, SPOS_FUNC_SEL_OFFSET, {24'($urandom), 8'(c)}, {3'($urandom), 1'b1}, d, r);
            check("bresp", 32'(SPOS_RESP_OKAY), 32'(r));
            repeat (8) @(posedge aclk);
            v = ref_sel(c, channel_0, channel_1, aux_status);
            axi(0, SPOS_FUNC_SEL_OFFSET, 32'h0, 4'h0, d, r);
            check("code", c, d);
            axi(0, SPOS_PIN_STATE_OFFSET, 32'h0, 4'h0, d, r);
            check("reserved", 32'(v[1]), 32'(d[31:1]));
            check("pin level", 32'(lvl), 32'(d[0]));
        end
        // Lane 0 off, read-only target, unmapped place: code stays 0x7F
        axi(1, SPOS_FUNC_SEL_OFFSET, 32'h30, 4'hE, d, r);
        axi(1, SPOS_PIN_STATE_OFFSET, 32'h30, 4'hF, d, r);
        axi(1, 12'h008, 32'h30, 4'hF, d, r);
        check("unmapped bresp", 32'(SPOS_RESP_DECERR), 32'(r));
        axi(0, 12'h008, 32'h0, 4'h0, d, r);
        check("unmapped rresp", 32'(SPOS_RESP_DECERR), 32'(r));
        check("unmapped rdata", 32'h0, d);
        axi(0, SPOS_FUNC_SEL_OFFSET, 32'h0, 4'h0, d, r);
        check("kept code", 32'h7F, d);
        // Reset in mid-run with a served code selected
        axi(1, SPOS_FUNC_SEL_OFFSET, 32'h2F, 4'h1, d, r);
        repeat (6) @(posedge aclk);
        aresetn <= 1'b0;
        model_code = 0;
        hold = 8;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        axi(0, SPOS_FUNC_SEL_OFFSET, 32'h0, 4'h0, d, r);
        check("code after reset", 32'(SPOS_FUNC_CODE_RESET), d);
        axi(0, SPOS_PIN_STATE_OFFSET, 32'h0, 4'h0, d, r);
        check("reserved after reset", 32'h1, 32'(d[1]));
        check("level after reset", 32'(lvl), 32'(d[0]));
        print_verdict();
    end
endmodule
bind spos_selector spos_props checker_u (.*);
`default_nettype wire
